// ==== rtl/lcdcd_top.v ====
// Command decoder for a dot matrix LCD driver
`include "lcdcd_consts.vh"
`default_nettype none
module lcdcd_top (
	// Clock and reset
	input wire clk_i,
	input wire resetn_i,
	// Host write and read strobes, select and data
	input wire wr_stb_i,
	input wire rd_stb_i,
	input wire cmd_data_select_i,
	input wire [7:0] data_i,
	// Display data path
	output reg ram_wr_o,
	output reg [7:0] ram_wdata_o,
	output wire [7:0] col_addr_o,
	// Settings
	output reg [5:0] start_line_o,
	output reg [3:0] page_addr_o,
	output reg com_reverse_o,
	output reg [2:0] power_en_o,
	output reg [2:0] resistor_ratio_o,
	output reg [5:0] volume_o,
	output reg [1:0] static_indicator_o,
	output reg [7:0] page_blink_o,
	output reg display_on_o,
	output reg rmw_active_o,
	output reg test_mode_o,
	output wire [1:0] wait_state_o
);
	// =====================================================
	// Internal state
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [2:0] power_set_q;
	reg reset_pend_q;
	wire cmd_wr;
	wire data_wr;
	wire data_rd;
	wire idle_cmd;
	wire ind_on_cmd;
	wire ind_off_cmd;
	wire rmw_enter;
	wire rmw_end;

	// =====================================================
	// Decode helpers
	// Static indicator command, either form
	function is_ind_cmd;
		input [7:0] b;
		begin
			is_ind_cmd = (b[7:1] == `LCDCD_PAT_IND);
		end
	endfunction

	// Five-bit opcode field match
	function is_op5;
		input [7:0] b;
		input [4:0] op;
		begin
			is_op5 = (b[7:3] == op);
		end
	endfunction

	// =====================================================
	// Strobe qualification
	assign cmd_wr = wr_stb_i && !cmd_data_select_i;
	assign data_wr = wr_stb_i && cmd_data_select_i;
	assign data_rd = rd_stb_i && cmd_data_select_i;
	assign idle_cmd = cmd_wr && (state_q == `LCDCD_ST_IDLE);
	assign ind_on_cmd = is_ind_cmd(data_i) && data_i[0];
	assign ind_off_cmd = is_ind_cmd(data_i) && !data_i[0];
	assign rmw_enter = idle_cmd && data_i == `LCDCD_CMD_RMW_ENTER && !rmw_active_o;
	assign rmw_end = idle_cmd && data_i == `LCDCD_CMD_RMW_END && rmw_active_o;
	assign wait_state_o = state_q;

	// =====================================================
	// Double-byte command sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			`LCDCD_ST_IDLE: begin
				if (cmd_wr && data_i == `LCDCD_CMD_VOL_MODE)
					state_d = `LCDCD_ST_VOL;
				else if (cmd_wr && ind_on_cmd)
					state_d = `LCDCD_ST_IND;
				else if (cmd_wr && data_i == `LCDCD_CMD_BLINK_MODE)
					state_d = `LCDCD_ST_BLINK;
			end
			default: begin
				// Any command write is the awaited second byte
				if (cmd_wr)
					state_d = `LCDCD_ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			state_q <= `LCDCD_ST_IDLE;
		else
			state_q <= state_d;
	end

	// =====================================================
	// Display data path
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ram_wr_o <= 1'b0;
			ram_wdata_o <= 8'h00;
		end else begin
			ram_wr_o <= data_wr;
			if (data_wr)
				ram_wdata_o <= data_i;
		end
	end

	// =====================================================
	// Software reset, applied the cycle after acceptance
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			reset_pend_q <= 1'b0;
		else
			reset_pend_q <= idle_cmd && data_i == `LCDCD_CMD_SW_RESET;
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_line_o <= 6'h00;
			page_addr_o <= 4'h0;
			test_mode_o <= 1'b0;
		end else if (reset_pend_q) begin
			start_line_o <= 6'h00;
			page_addr_o <= 4'h0;
			test_mode_o <= 1'b0;
		end
	end

	// =====================================================
	// Single-byte settings; a command in the reset cycle wins
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			com_reverse_o <= 1'b0;
		else if (idle_cmd && data_i[7:4] == `LCDCD_NIB_COM_DIR)
			com_reverse_o <= data_i[`LCDCD_COM_DIR_BIT];
		else if (reset_pend_q)
			com_reverse_o <= 1'b0;
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			power_set_q <= 3'h0;
		else if (idle_cmd && is_op5(data_i, `LCDCD_PAT_POWER))
			power_set_q <= data_i[2:0];
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			resistor_ratio_o <= `LCDCD_RATIO_RST;
		else if (idle_cmd && is_op5(data_i, `LCDCD_PAT_RATIO))
			resistor_ratio_o <= data_i[2:0];
		else if (reset_pend_q)
			resistor_ratio_o <= `LCDCD_RATIO_RST;
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			display_on_o <= 1'b0;
		else if (idle_cmd && data_i == `LCDCD_CMD_DISP_OFF)
			display_on_o <= 1'b0;
		else if (idle_cmd && data_i == `LCDCD_CMD_DISP_ON)
			display_on_o <= 1'b1;
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			rmw_active_o <= 1'b0;
		else if (idle_cmd && data_i == `LCDCD_CMD_RMW_ENTER)
			rmw_active_o <= 1'b1;
		else if (idle_cmd && data_i == `LCDCD_CMD_RMW_END)
			rmw_active_o <= 1'b0;
		else if (reset_pend_q)
			rmw_active_o <= 1'b0;
	end

	// =====================================================
	// Double-byte settings
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			volume_o <= `LCDCD_VOL_RST;
		else if (cmd_wr && state_q == `LCDCD_ST_VOL)
			volume_o <= data_i[5:0];
		else if (reset_pend_q)
			volume_o <= `LCDCD_VOL_RST;
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			static_indicator_o <= `LCDCD_IND_RST;
		else if (cmd_wr && state_q == `LCDCD_ST_IND)
			static_indicator_o <= data_i[1:0];
		else if (idle_cmd && ind_off_cmd)
			static_indicator_o <= `LCDCD_IND_RST;
		else if (reset_pend_q)
			static_indicator_o <= `LCDCD_IND_RST;
	end

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			page_blink_o <= 8'h00;
		else if (cmd_wr && state_q == `LCDCD_ST_BLINK)
			page_blink_o <= data_i;
	end

	// =====================================================
	// Power enables gated by display state
	always @* begin
		power_en_o = display_on_o ? power_set_q : 3'h0;
	end

	// =====================================================
	// Column address counter
	lcdcd_col_addr u_col (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.clear_i(reset_pend_q),
		.rmw_enter_i(rmw_enter),
		.rmw_end_i(rmw_end),
		.rmw_active_i(rmw_active_o),
		.data_wr_i(data_wr),
		.data_rd_i(data_rd),
		.col_addr_o(col_addr_o)
	);
endmodule
`default_nettype wire

// ==== rtl/lcdcd_consts.vh ====
// Command codes, field positions and reset values of the LCD command decoder
`ifndef LCDCD_CONSTS_VH
`define LCDCD_CONSTS_VH
`define LCDCD_CMD_RMW_ENTER 8'hE0
`define LCDCD_CMD_RMW_END 8'hEE
`define LCDCD_CMD_SW_RESET 8'hE2
`define LCDCD_CMD_VOL_MODE 8'h81
`define LCDCD_CMD_BLINK_MODE 8'hA5
`define LCDCD_CMD_DISP_OFF 8'hAE
`define LCDCD_CMD_DISP_ON 8'hAF
`define LCDCD_NIB_COM_DIR 4'hC
`define LCDCD_PAT_POWER 5'h05
`define LCDCD_PAT_RATIO 5'h04
`define LCDCD_PAT_IND 7'h56
`define LCDCD_COM_DIR_BIT 3
`define LCDCD_VOL_W 6
`define LCDCD_VOL_RST 6'h20
`define LCDCD_RATIO_RST 3'h0
`define LCDCD_IND_RST 2'h0
`define LCDCD_ST_IDLE 2'h0
`define LCDCD_ST_VOL 2'h1
`define LCDCD_ST_IND 2'h2
`define LCDCD_ST_BLINK 2'h3
`endif

// ==== rtl/lcdcd_col_addr.v ====
// Column address counter with read/modify/write save and restore
`default_nettype none
module lcdcd_col_addr (
	// Clock and reset
	input wire clk_i,
	input wire resetn_i,
	// Control
	input wire clear_i,
	input wire rmw_enter_i,
	input wire rmw_end_i,
	input wire rmw_active_i,
	input wire data_wr_i,
	input wire data_rd_i,
	// State
	output reg [7:0] col_addr_o
);
	reg [7:0] saved_q;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			col_addr_o <= 8'h00;
			saved_q <= 8'h00;
		end else if (clear_i) begin
			col_addr_o <= 8'h00;
		end else if (rmw_end_i) begin
			col_addr_o <= saved_q;
		end else begin
			if (rmw_enter_i)
				saved_q <= col_addr_o;
			if (data_wr_i || (data_rd_i && !rmw_active_i))
				col_addr_o <= col_addr_o + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== dv/lcdcd_props.sv ====
// Checker bound to the LCD command decoder
`default_nettype none
module lcdcd_props (
	// Host side
	input wire clk_i,
	input wire resetn_i,
	input wire wr_stb_i,
	input wire cmd_data_select_i,
	input wire [7:0] data_i,
	// Settings
	input wire ram_wr_o,
	input wire com_reverse_o,
	input wire [2:0] power_en_o,
	input wire [2:0] resistor_ratio_o,
	input wire [5:0] volume_o,
	input wire [1:0] static_indicator_o,
	input wire [7:0] page_blink_o,
	input wire display_on_o,
	input wire [1:0] wait_state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wire cw = wr_stb_i && !cmd_data_select_i;
	wire idl = wait_state_o == 2'h0;
	a_data_write: assert property (wr_stb_i && cmd_data_select_i |=> ram_wr_o)
		else $error("no ram write");
	a_scan_dir: assert property (cw && idl && data_i[7:4] == 4'hC |=> com_reverse_o == $past(data_i[3]))
		else $error("scan");
	a_power_mask: assert property (!display_on_o |-> power_en_o == 3'h0)
		else $error("power");
	a_ratio_load: assert property (cw && idl && data_i[7:3] == 5'h04 |=> resistor_ratio_o == $past(data_i[2:0]))
		else $error("ratio");
	a_vol_enter: assert property (cw && idl && data_i == 8'h81 |=> wait_state_o == 2'h1)
		else $error("vol mode");
	a_vol_store: assert property (cw && wait_state_o == 2'h1 |=> volume_o == $past(data_i[5:0]) && idl)
		else $error("vol");
	a_ind_store: assert property (cw && wait_state_o == 2'h2 |=> static_indicator_o == $past(data_i[1:0]))
		else $error("ind");
	a_ind_single: assert property (cw && idl && data_i == 8'hAC |=> idl)
		else $error("ind off");
	a_blink_store: assert property (cw && wait_state_o == 2'h3 |=> page_blink_o == $past(data_i))
		else $error("blink");
	a_soft_reset: assert property (cw && idl && data_i == 8'hE2 |=> ##1 volume_o == 6'h20)
		else $error("reset");
endmodule
bind lcdcd_top lcdcd_props props (.clk_i, .resetn_i, .wr_stb_i, .cmd_data_select_i, .data_i, .ram_wr_o,
	.com_reverse_o, .power_en_o, .resistor_ratio_o, .volume_o, .static_indicator_o, .page_blink_o,
	.display_on_o, .wait_state_o);
`default_nettype wire

// ==== dv/lcdcd_host.sv ====
// Host model writing bytes to the decoder
`default_nettype none
module lcdcd_host (
	// Clock
	input wire clk_i,
	// Bus
	output logic wr_o,
	output logic sel_o,
	output logic [7:0] dat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wr_o = 1'b0;
		sel_o = 1'b0;
		dat_o = 8'h00;
	end
	task automatic put(input logic s, input logic [7:0] b);
		@(posedge clk_i);
		wr_o <= 1'b1;
		sel_o <= s;
		dat_o <= b;
	endtask
	// Released data shows the inverse
	task automatic rel();
		@(posedge clk_i);
		wr_o <= 1'b0;
		dat_o <= ~dat_o;
	endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench of the command decoder
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	wire wr_stb_i, cmd_data_select_i, com_reverse_o, display_on_o;
	wire [7:0] data_i, col_addr_o, page_blink_o;
	wire [2:0] power_en_o, resistor_ratio_o;
	wire [5:0] volume_o;
	wire [1:0] static_indicator_o, wait_state_o;
	wire rmw_active_o, test_mode_o;
	wire [7:0] ram_wdata_o;
	wire [5:0] start_line_o;
	wire [3:0] page_addr_o;
	logic rd_stb_i = 1'b0;
	int err_count = 0;
	int compares = 0;
	always #4 clk_i = ~clk_i;
	lcdcd_host host (.clk_i, .wr_o(wr_stb_i), .sel_o(cmd_data_select_i), .dat_o(data_i));
	lcdcd_top dut (.clk_i, .resetn_i, .wr_stb_i, .rd_stb_i, .cmd_data_select_i, .data_i, .ram_wr_o(),
		.ram_wdata_o, .col_addr_o, .start_line_o, .page_addr_o, .com_reverse_o, .power_en_o,
		.resistor_ratio_o, .volume_o, .static_indicator_o, .page_blink_o, .display_on_o, .rmw_active_o,
		.test_mode_o, .wait_state_o);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic fin();
		host.rel();
		@(posedge clk_i);
		#1;
	endtask
	task automatic t_scan();
		host.put(0, 8'hCF);
		fin();
		chk(com_reverse_o, 8'h01);
		host.put(0, 8'hC7);
		fin();
		chk(com_reverse_o, 8'h00);
	endtask
	task automatic t_power();
		host.put(0, 8'h2F);
		fin();
		chk(power_en_o, 8'h00);
		host.put(0, 8'hAF);
		host.put(0, 8'h2D);
		fin();
		chk(power_en_o, 8'h05);
		chk(display_on_o, 8'h01);
		host.put(0, 8'hAE);
		fin();
		chk(power_en_o, 8'h00);
		host.put(0, 8'hAF);
		fin();
		chk(power_en_o, 8'h05);
	endtask
	task automatic t_pairs();
		host.put(0, 8'h27);
		host.put(0, 8'h81);
		fin();
		chk(wait_state_o, 8'h01);
		host.put(1, 8'h55);
		host.put(0, 8'hC8);
		host.put(0, 8'hAD);
		host.put(0, 8'hC6);
		host.put(0, 8'hA5);
		host.put(0, 8'hE2);
		fin();
		chk(resistor_ratio_o, 8'h07);
		chk(volume_o, 8'h08);
		chk(static_indicator_o, 8'h02);
		chk(page_blink_o, 8'hE2);
		chk(com_reverse_o, 8'h00);
	endtask
	task automatic t_reset();
		host.put(0, 8'hAC);
		fin();
		chk(static_indicator_o, 8'h00);
		chk(wait_state_o, 8'h00);
		host.put(0, 8'hCB);
		fin();
		chk(com_reverse_o, 8'h01);
		host.put(0, 8'hE2);
		fin();
		@(posedge clk_i);
		#1;
		chk(volume_o, 8'h20);
		chk(resistor_ratio_o, 8'h00);
		chk(com_reverse_o, 8'h00);
		chk(col_addr_o, 8'h00);
		chk(start_line_o, 8'h00);
		chk(page_addr_o, 8'h00);
		chk(rmw_active_o, 8'h00);
		chk(test_mode_o, 8'h00);
	endtask
	task automatic rd_pulse();
		@(posedge clk_i);
		rd_stb_i <= 1'b1;
		@(posedge clk_i);
		rd_stb_i <= 1'b0;
		#1;
	endtask
	task automatic t_rmw();
		host.put(1, 8'h11);
		host.put(0, 8'hE0);
		host.put(1, 8'h22);
		fin();
		chk(col_addr_o, 8'h02);
		chk(rmw_active_o, 8'h01);
		chk(ram_wdata_o, 8'h22);
		rd_pulse();
		chk(col_addr_o, 8'h02);
		host.put(0, 8'hEE);
		fin();
		chk(col_addr_o, 8'h01);
		chk(rmw_active_o, 8'h00);
	endtask
	task automatic wrap_up();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_scan();
		t_power();
		t_pairs();
		t_reset();
		t_rmw();
		wrap_up();
	end
	initial begin
		#5000;
		err_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
